// ===== offset_seq_defs.svh
// Constants for the offset reversal sequencer
`ifndef OFFSET_SEQ_DEFS_SVH
`define OFFSET_SEQ_DEFS_SVH
`define OSQ_SETTLE_RST   16'h0001
`define OSQ_CAL_PERIOD   24'h00_1000
`define OSQ_SIGN_POS     1'b0
`define OSQ_SIGN_NEG     1'b1
`endif

// ===== offset_seq_pkg.sv
// Types for the offset reversal sequencer
package offset_seq_pkg;
    typedef enum logic [7:0] {
        ST_IDLE   = 8'b0000_0001,
        ST_SELECT = 8'b0000_0010,
        ST_SETTLE = 8'b0000_0100,
        ST_CONV   = 8'b0000_1000,
        ST_WAIT   = 8'b0001_0000,
        ST_OFFCV  = 8'b0010_0000,
        ST_OFFWT  = 8'b0100_0000,
        ST_DONE   = 8'b1000_0000
    } seq_state_type;

    typedef enum logic [1:0] {
        OFF_NONE  = 2'b00,
        OFF_START = 2'b01,
        OFF_CAL   = 2'b10
    } offset_mode_type;
endpackage : offset_seq_pkg

// ===== pin_sync.sv
// Two-stage synchroniser for one pin-level input
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic d_i,
    output var  logic q_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_type;

    sync_state_type st_r;
    sync_state_type st_nxt;

    // Second stage only ever reads the first
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = d_i;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.sync;
endmodule : pin_sync
`default_nettype wire

// ===== offset_reversal_sequencer.sv
// Measurement sequencer with input swap, excitation flip and offset correction
`timescale 1ns/1ps
`include "offset_seq_defs.svh"
`default_nettype none
module offset_reversal_sequencer #(
    parameter int DW         = 24,
    parameter int SETTLE_W   = 16,
    parameter int CAL_PERIOD = `OSQ_CAL_PERIOD
) (
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                start_i,
    input  wire logic                differential_i,
    input  wire logic                ratiometric_i,
    input  wire logic                input_swap_enable_i,
    input  wire logic                excite_flip_enable_i,
    input  wire logic                offset_at_start_enable_i,
    input  wire logic [SETTLE_W-1:0] settle_cycles_i,
    input  wire logic                conv_done_i,
    input  wire logic [DW-1:0]       conv_data_i,
    output var  logic                busy_o,
    output var  logic                mux_select_o,
    output var  logic                input_swap_o,
    output var  logic                excite_on_o,
    output var  logic                excite_neg_o,
    output var  logic                amp_ground_o,
    output var  logic                conv_start_o,
    output var  logic                result_valid_o,
    output var  logic [DW-1:0]       result_o
);
    localparam int AW = DW + 3;

    typedef struct packed {
        offset_seq_pkg::seq_state_type   state;
        offset_seq_pkg::offset_mode_type omode;
        logic                            busy;
        logic                            sel;
        logic                            swap;
        logic                            exc_on;
        logic                            exc_neg;
        logic                            gnd;
        logic                            conv;
        logic                            valid;
        logic                            cal_pend;
        logic                            cal_run;
        logic                            rev_in;
        logic                            rev_ex;
        logic [1:0]                      step;
        logic [SETTLE_W-1:0]             settle_cnt;
        logic [23:0]                     cal_cnt;
        logic [DW-1:0]                   offset;
        logic [DW-1:0]                   cal_offset;
        logic signed [AW-1:0]            acc;
        logic [DW-1:0]                   result;
    } seq_regs_type;

    seq_regs_type st_r;
    seq_regs_type st_nxt;

    logic done_s;

    // Converter handshake arrives from the analog side, so resync it
    pin_sync u_done_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .d_i    (conv_done_i),
        .q_o    (done_s)
    );

    logic signed [AW-1:0] sample_ext;
    logic                 sample_neg;
    logic [1:0]           last_step;
    logic signed [AW-1:0] final_val;

    always_comb begin
        sample_neg = st_r.exc_neg ^ st_r.swap;
        sample_ext = AW'($signed(conv_data_i)) - AW'($signed(st_r.offset));
        last_step  = (st_r.rev_in && st_r.rev_ex) ? 2'd3 :
                     ((st_r.rev_in || st_r.rev_ex) ? 2'd1 : 2'd0);
        // Divide by the number of conversions taken
        unique case (last_step)
            2'd3:    final_val = st_r.acc >>> 2;
            2'd1:    final_val = st_r.acc >>> 1;
            default: final_val = st_r.acc;
        endcase
    end

    // Whole state machine in one combinational pass
    always_comb begin
        st_nxt       = st_r;
        st_nxt.conv  = 1'b0;
        st_nxt.valid = 1'b0;

        unique case (st_r.state)
            offset_seq_pkg::ST_IDLE: begin
                st_nxt.busy = 1'b0;
                if (st_r.cal_pend) begin
                    // Calibration only between measurements, so offsets may be stale
                    st_nxt.cal_pend = 1'b0;
                    st_nxt.cal_run  = 1'b1;
                    st_nxt.gnd      = 1'b1;
                    st_nxt.busy     = 1'b1;
                    st_nxt.conv     = 1'b1;
                    st_nxt.state    = offset_seq_pkg::ST_OFFWT;
                end else if (start_i) begin
                    st_nxt.busy   = 1'b1;
                    st_nxt.rev_in = input_swap_enable_i && differential_i;
                    st_nxt.rev_ex = excite_flip_enable_i && ratiometric_i;
                    st_nxt.acc    = '0;
                    st_nxt.step   = 2'd0;
                    st_nxt.sel    = 1'b1;
                    st_nxt.swap   = 1'b0;
                    st_nxt.offset = '0;
                    // offset source when no input swap
                    if (input_swap_enable_i && differential_i) begin
                        st_nxt.omode = offset_seq_pkg::OFF_NONE;
                    end else if (!differential_i && offset_at_start_enable_i && !ratiometric_i) begin
                        st_nxt.omode = offset_seq_pkg::OFF_START;
                    end else begin
                        st_nxt.omode  = offset_seq_pkg::OFF_CAL;
                        st_nxt.offset = st_r.cal_offset;
                    end
                    st_nxt.state = offset_seq_pkg::ST_SELECT;
                end
            end
            offset_seq_pkg::ST_SELECT: begin
                if (st_r.omode == offset_seq_pkg::OFF_START) begin
                    st_nxt.gnd   = 1'b1;
                    st_nxt.conv  = 1'b1;
                    st_nxt.state = offset_seq_pkg::ST_OFFCV;
                end else begin
                    st_nxt.exc_on     = st_r.rev_ex || ratiometric_i;
                    st_nxt.exc_neg    = `OSQ_SIGN_POS;
                    st_nxt.settle_cnt = settle_cycles_i;
                    st_nxt.state      = offset_seq_pkg::ST_SETTLE;
                end
            end
            offset_seq_pkg::ST_OFFCV: begin
                if (done_s) begin
                    st_nxt.offset     = conv_data_i;
                    st_nxt.gnd        = 1'b0;
                    st_nxt.exc_on     = ratiometric_i;
                    st_nxt.settle_cnt = settle_cycles_i;
                    st_nxt.state      = offset_seq_pkg::ST_SETTLE;
                end
            end
            offset_seq_pkg::ST_SETTLE: begin
                if (st_r.settle_cnt == '0) begin
                    st_nxt.conv  = 1'b1;
                    st_nxt.state = offset_seq_pkg::ST_CONV;
                end else begin
                    st_nxt.settle_cnt = st_r.settle_cnt - SETTLE_W'(1);
                end
            end
            offset_seq_pkg::ST_CONV: begin
                if (done_s) begin
                    st_nxt.acc = sample_neg ? (st_r.acc - sample_ext) : (st_r.acc + sample_ext);
                    st_nxt.state = offset_seq_pkg::ST_WAIT;
                end
            end
            offset_seq_pkg::ST_WAIT: begin
                if (st_r.step == last_step) begin
                    st_nxt.exc_on = 1'b0;
                    st_nxt.sel    = 1'b0;
                    st_nxt.swap   = 1'b0;
                    st_nxt.state  = offset_seq_pkg::ST_DONE;
                end else begin
                    st_nxt.step = st_r.step + 2'd1;
                    // flip excitation every step, swap inputs midway
                    if (st_r.rev_ex) begin
                        st_nxt.exc_neg = ~st_r.exc_neg;
                    end
                    if (st_r.rev_in && (!st_r.rev_ex || st_r.step == 2'd1)) begin
                        st_nxt.swap = 1'b1;
                    end
                    st_nxt.settle_cnt = settle_cycles_i;
                    st_nxt.state      = offset_seq_pkg::ST_SETTLE;
                end
            end
            offset_seq_pkg::ST_OFFWT: begin
                if (done_s) begin
                    st_nxt.cal_offset = conv_data_i;
                    st_nxt.cal_run    = 1'b0;
                    st_nxt.gnd        = 1'b0;
                    st_nxt.busy       = 1'b0;
                    st_nxt.state      = offset_seq_pkg::ST_IDLE;
                end
            end
            offset_seq_pkg::ST_DONE: begin
                st_nxt.result  = final_val[DW-1:0];
                st_nxt.valid   = 1'b1;
                st_nxt.exc_neg = `OSQ_SIGN_POS;
                st_nxt.busy    = 1'b0;
                st_nxt.state   = offset_seq_pkg::ST_IDLE;
            end
            default: begin
                st_nxt.state = offset_seq_pkg::ST_IDLE;
            end
        endcase

        // periodic calibration timer
        // Placed after the case so a new tick beats a same-cycle clear
        if (st_r.cal_cnt == 24'(CAL_PERIOD - 1)) begin
            st_nxt.cal_cnt  = '0;
            st_nxt.cal_pend = 1'b1;
        end else begin
            st_nxt.cal_cnt = st_r.cal_cnt + 24'h00_0001;
        end
    end

    // one clock for every phase keeps polarity times equal
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r            <= '0;
            st_r.state      <= offset_seq_pkg::ST_IDLE;
            st_r.settle_cnt <= SETTLE_W'(`OSQ_SETTLE_RST);
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign busy_o         = st_r.busy;
    assign mux_select_o   = st_r.sel;
    assign input_swap_o   = st_r.swap;
    assign excite_on_o    = st_r.exc_on;
    assign excite_neg_o   = st_r.exc_neg;
    assign amp_ground_o   = st_r.gnd;
    assign conv_start_o   = st_r.conv;
    assign result_valid_o = st_r.valid;
    assign result_o       = st_r.result;
endmodule : offset_reversal_sequencer
`default_nettype wire

// ===== offset_seq_checker.sv
// Port-level assertions for the offset reversal sequencer
`timescale 1ns/1ps
`default_nettype none
module offset_seq_checker #(
    parameter int SETTLE_W = 16
) (
    input wire logic                mclk_i,
    input wire logic                rst_i,
    input wire logic                differential_i,
    input wire logic                ratiometric_i,
    input wire logic                input_swap_enable_i,
    input wire logic                excite_flip_enable_i,
    input wire logic                offset_at_start_enable_i,
    input wire logic [SETTLE_W-1:0] settle_cycles_i,
    input wire logic                mux_select_o,
    input wire logic                input_swap_o,
    input wire logic                excite_on_o,
    input wire logic                excite_neg_o,
    input wire logic                amp_ground_o,
    input wire logic                conv_start_o,
    input wire logic                result_valid_o
);
    logic [15:0] still_r;
    logic [15:0] pos_r;
    logic [15:0] neg_r;
    logic [2:0]  nconv_r;
    logic        gnd_r;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Tallies cleared per measurement; still_r saturates so long idles cannot wrap
    always_ff @(posedge mclk_i) begin
        if (rst_i || $changed(excite_neg_o) || $changed(input_swap_o) || $rose(mux_select_o)) still_r <= '0;
        else still_r <= still_r + {15'h0000, still_r != 16'hFFFF};
        pos_r <= (rst_i || !excite_on_o) ? '0 : pos_r + {15'h0000, !excite_neg_o};
        neg_r <= (rst_i || !excite_on_o) ? '0 : neg_r + {15'h0000, excite_neg_o};
        if (rst_i || result_valid_o) nconv_r <= '0;
        else nconv_r <= nconv_r + {2'b00, conv_start_o && mux_select_o && !amp_ground_o};
        if (rst_i || result_valid_o) gnd_r <= 1'b0;
        else if (conv_start_o && amp_ground_o && mux_select_o) gnd_r <= 1'b1;
    end
    swap_gate_a : assert property (input_swap_o |-> input_swap_enable_i && differential_i)
        else $error("input swap without enable");
    flip_gate_a : assert property (excite_neg_o |-> excite_flip_enable_i && ratiometric_i)
        else $error("excitation flip without enable");
    conv_count_a : assert property (result_valid_o |-> nconv_r == ((input_swap_enable_i && differential_i) ? 3'd2 : 3'd1)
        << (excite_flip_enable_i && ratiometric_i)) else $error("wrong number of conversions");
    settle_time_a : assert property (conv_start_o && !amp_ground_o |-> still_r >= settle_cycles_i)
        else $error("conversion before settling");
    first_pos_a : assert property ($rose(excite_on_o) |-> !excite_neg_o)
        else $error("first excitation not positive");
    swap_order_a : assert property ($rose(input_swap_o) && excite_on_o |-> ##[0:1] !excite_neg_o)
        else $error("swap not paired with excitation reversal");
    equal_excite_a : assert property ($fell(excite_on_o) && neg_r != 0 |-> pos_r == neg_r)
        else $error("unequal excitation time per polarity");
    start_offset_a : assert property (result_valid_o && offset_at_start_enable_i && !differential_i
        && !ratiometric_i |-> gnd_r) else $error("no grounded offset conversion");
    cal_offset_a : assert property (result_valid_o && !offset_at_start_enable_i |-> !gnd_r)
        else $error("grounded conversion inside measurement without offset at start");
endmodule : offset_seq_checker
bind offset_reversal_sequencer offset_seq_checker #(.SETTLE_W(SETTLE_W)) offset_seq_checker_i (
    .mclk_i, .rst_i, .differential_i, .ratiometric_i, .input_swap_enable_i, .excite_flip_enable_i,
    .offset_at_start_enable_i, .settle_cycles_i, .mux_select_o, .input_swap_o, .excite_on_o,
    .excite_neg_o, .amp_ground_o, .conv_start_o, .result_valid_o);
`default_nettype wire

// ===== conv_model.sv
// Converter and input path model with an offset taken from ofs_i
`timescale 1ns/1ps
`default_nettype none
module conv_model (
    input  wire logic        mclk_i,
    input  wire logic        start_i,
    input  wire logic        neg_i,
    input  wire logic        gnd_i,
    input  wire logic [23:0] sig_i,
    input  wire logic [23:0] ofs_i,
    input  wire logic [7:0]  dly_i,
    output var  logic        done_o,
    output var  logic [23:0] data_o
);
    initial done_o = 1'b0;
    initial data_o = 24'h00_0000;
    // Polarity flips the signal but never the offset, so reversal or subtracting a grounded reading cancels it
    always @(posedge mclk_i) begin
        if (start_i) begin
            data_o <= gnd_i ? ofs_i : (neg_i ? ofs_i - sig_i : ofs_i + sig_i);
            repeat (dly_i) @(posedge mclk_i);
            done_o <= 1'b1;
            repeat (2) @(posedge mclk_i);
            done_o <= 1'b0;
        end
    end
endmodule : conv_model
`default_nettype wire

// ===== offset_reversal_sequencer_bench.sv
// Self-checking bench for the offset reversal sequencer
`timescale 1ns/1ps
`default_nettype none
module offset_reversal_sequencer_bench;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        start_i = 1'b0;
    logic        differential_i = 1'b0;
    logic        ratiometric_i = 1'b0;
    logic        input_swap_enable_i = 1'b0;
    logic        excite_flip_enable_i = 1'b0;
    logic        offset_at_start_enable_i = 1'b0;
    logic [15:0] settle_cycles_i = 16'h0003;
    logic [23:0] sig_r = 24'h00_0400;
    logic [23:0] ofs_r = 24'h00_0025;
    logic [7:0]  dly_r = 8'h02;
    logic        conv_done_i;
    logic [23:0] conv_data_i;
    logic        busy_o, mux_select_o, input_swap_o, excite_on_o, excite_neg_o, amp_ground_o;
    logic        conv_start_o, result_valid_o;
    logic [23:0] result_o;
    int          n_fail = 0;
    int          checks_done = 0;
    always #12.5 mclk_i = ~mclk_i;
    offset_reversal_sequencer #(.CAL_PERIOD(64)) offset_reversal_sequencer_i (
        .mclk_i, .rst_i, .ce_i(1'b1), .start_i, .differential_i, .ratiometric_i, .input_swap_enable_i,
        .excite_flip_enable_i, .offset_at_start_enable_i, .settle_cycles_i, .conv_done_i, .conv_data_i,
        .busy_o, .mux_select_o, .input_swap_o, .excite_on_o, .excite_neg_o, .amp_ground_o, .conv_start_o,
        .result_valid_o, .result_o);
    conv_model conv_model_i (.mclk_i, .start_i(conv_start_o), .neg_i(excite_neg_o ^ input_swap_o),
        .gnd_i(amp_ground_o), .sig_i(sig_r), .ofs_i(ofs_r), .dly_i(dly_r), .done_o(conv_done_i),
        .data_o(conv_data_i));
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Config order: differential, ratiometric, swap, flip, offset at start
    task automatic measure(input logic [4:0] cfg, input logic [23:0] sig);
        int n;
        n = 0;
        @(posedge mclk_i);
        {differential_i, ratiometric_i, input_swap_enable_i, excite_flip_enable_i, offset_at_start_enable_i} <= cfg;
        sig_r <= sig;
        start_i <= 1'b1;
        // Busy alone may be a calibration, so wait for the measurement to select its inputs
        do begin @(negedge mclk_i); n++; end while (mux_select_o !== 1'b1 && n < 500);
        check("mux_select_o", 24'h00_0001, {23'h00_0000, mux_select_o});
        @(posedge mclk_i);
        start_i <= 1'b0;
        do begin @(negedge mclk_i); n++; end while (result_valid_o !== 1'b1 && n < 2000);
        check("result_valid_o", 24'h00_0001, {23'h00_0000, result_valid_o});
        check("result_o", sig, result_o);
    endtask : measure
    task automatic close_out;
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    // Hang guard, far beyond the fewer than a thousand cycles the sequence needs
    initial begin
        repeat (30000) @(posedge mclk_i);
        n_fail++;
        close_out();
    end
    // Main sequence; first waits let background calibration store the offset
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        check("idle outputs", 24'h00_0000, {18'h0_0000, busy_o, excite_on_o, input_swap_o, conv_start_o,
            result_valid_o, amp_ground_o});
        repeat (150) @(posedge mclk_i);
        measure(5'b11110, 24'h00_0400);
        measure(5'b10100, 24'hFF_FC18);
        measure(5'b01010, 24'h01_2345);
        measure(5'b01000, 24'h00_0400);
        measure(5'b10000, 24'hFF_FC18);
        measure(5'b00001, 24'h01_2345);
        measure(5'b00000, 24'h00_0400);
        @(posedge mclk_i);
        dly_r <= 8'h14;
        settle_cycles_i <= 16'h0000;
        measure(5'b11110, 24'hFF_FC18);
        @(posedge mclk_i);
        ofs_r <= 24'hFF_FFB0;
        repeat (150) @(posedge mclk_i);
        measure(5'b10000, 24'h01_2345);
        close_out();
    end
endmodule : offset_reversal_sequencer_bench
`default_nettype wire
